// ==== logic/nand_rd_defs.svh ====
`ifndef NAND_RD_DEFS_SVH
`define NAND_RD_DEFS_SVH
/*
 * Constants of the host-side NAND read sequencer: command codes, address
 * cycle layout, plane bit positions and timing figures.
 * Assumes a 25 MHz clock and an 8-bit asynchronous NAND bus.
 *
// Summary of operation
// - Page read: setup, five addresses, confirm
// - After status read, reissue setup before data
// - Cache mode starts with full page read
// - Two-plane: two addresses differing in plane
// - Plane select command before reading plane data
// - No enhanced status during two-plane read
// - Column change gives data from new column
// - Column change only within loaded page
// - Wait write-to-read delay after plane select
// - Column-only change uses single-plane command
// - Address cycles: column 0-11, row 12-29
 */

// Command codes
`define CMD_READ_SETUP   8'h00
`define CMD_READ_CONFIRM 8'h30
`define CMD_CACHE_SEQ    8'h31
`define CMD_CACHE_LAST   8'h3F
`define CMD_COL_CHANGE   8'h05
`define CMD_PLANE_SELECT 8'h06
`define CMD_OUT_CONFIRM  8'hE0
`define CMD_STATUS       8'h70

// Address layout
`define ADDR_CYC_FULL    3'h5
`define ADDR_CYC_COL     3'h2
`define ADDR_B0          7:0
`define ADDR_B1          11:8
`define ADDR_B2          19:12
`define ADDR_B3          27:20
`define ADDR_B4          29:28
`define ADDR_COL         11:0
`define PLANE_BIT        18
`define PLANE_IO_BIT     6
`define PAGE_BYTES_DEF   4096

// Timing
`define CLK_PERIOD_NS    40
`define T_STROBE_NS      50
`define T_WB_NS          100
`define T_WHR_NS         60
`define STROBE_CYC       ((`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WB_CYC           ((`T_WB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WHR_CYC          ((`T_WHR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== logic/nand_rd_pkg.sv ====
/*
 * Types shared by the NAND read sequencer and its bus-cycle engine.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package nand_rd_pkg;

    typedef enum logic [2:0] {
        OP_PAGE_READ, OP_CACHE_SEQ, OP_CACHE_RAND, OP_CACHE_LAST,
        OP_TWO_PLANE, OP_COL_CHANGE, OP_PLANE_SELECT, OP_STATUS
    } op_e;

    typedef enum logic [1:0] {CYC_CMD, CYC_ADDR, CYC_READ} cyc_kind_e;

    typedef enum logic [3:0] {
        S_IDLE, S_RESUME, S_SETUP, S_ADDR, S_SETUP2, S_ADDR2,
        S_CONFIRM, S_TWB, S_BUSY, S_WRITE_TO_READ_DELAY, S_DATA
    } state_e;

    typedef struct packed {
        state_e state;
        op_e op;
        logic [29:0] addr;
        logic [2:0] idx;
        logic [12:0] len;
        logic [7:0] wait_cnt;
        logic cache_valid;
        logic status_mode;
        logic [7:0] rd_data;
        logic rd_valid;
        logic done;
        logic err;
        logic [7:0] status;
        logic ce;
    } seq_s;

    typedef struct packed {
        logic active;
        logic phase;
        logic [7:0] cnt;
        cyc_kind_e kind;
        logic [7:0] dat;
        logic [7:0] rd;
        logic cle;
        logic ale;
        logic we;
        logic re;
        logic oe;
    } eng_s;

endpackage

// ==== logic/nand_cyc_if.sv ====
/*
 * Request/answer link between the sequencer and the bus-cycle engine.
 * Assumes both ends run on the same clock.
 */
interface nand_cyc_if;
    logic start;
    nand_rd_pkg::cyc_kind_e kind;
    logic [7:0] wr_byte;
    logic done;
    logic [7:0] rd_byte;

    modport seq (output start, output kind, output wr_byte, input done, input rd_byte);
    modport eng (input start, input kind, input wr_byte, output done, output rd_byte);
endinterface

// ==== logic/nand_bus_cycle.sv ====
/*
 * One NAND bus cycle at a time: command latch, address latch or data read.
 * Assumes io_in is synchronous to clk_in and chip enable is driven elsewhere.
 */
`include "nand_rd_defs.svh"

module nand_bus_cycle #(
    parameter int PHASE_CYC = `STROBE_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Cycle requests
    nand_cyc_if.eng cyc,
    // Flash pins
    input wire logic [7:0] io_in,
    output logic cle_out,
    output logic ale_out,
    output logic we_n_out,
    output logic re_n_out,
    output logic [7:0] io_out,
    output logic io_oe_out
);

    nand_rd_pkg::eng_s s_reg, s_next;
    logic tick;

    if (PHASE_CYC < 1 || PHASE_CYC > 255) begin : g_chk
        $error("PHASE_CYC out of range");
    end

    // Phase divider enable
    assign tick = s_reg.active && (s_reg.cnt == 8'(PHASE_CYC - 1));
    assign cyc.done = tick && s_reg.phase;
    assign cyc.rd_byte = s_reg.rd;

    always_comb begin
        s_next = s_reg;
        if (!s_reg.active) begin
            if (cyc.start) begin
                s_next.active = 1'b1;
                s_next.phase = 1'b0;
                s_next.cnt = 8'h00;
                s_next.kind = cyc.kind;
                s_next.dat = cyc.wr_byte;
                s_next.cle = (cyc.kind == nand_rd_pkg::CYC_CMD);
                s_next.ale = (cyc.kind == nand_rd_pkg::CYC_ADDR);
                s_next.we = (cyc.kind != nand_rd_pkg::CYC_READ);
                s_next.re = (cyc.kind == nand_rd_pkg::CYC_READ);
                s_next.oe = (cyc.kind != nand_rd_pkg::CYC_READ);
            end
        end else if (tick) begin
            s_next.cnt = 8'h00;
            if (!s_reg.phase) begin
                s_next.phase = 1'b1;
                s_next.we = 1'b0;
                s_next.re = 1'b0;
                // Sample at the rising read strobe, data has had a full phase to settle
                if (s_reg.kind == nand_rd_pkg::CYC_READ) begin
                    s_next.rd = io_in;
                end
            end else begin
                s_next.active = 1'b0;
                s_next.cle = 1'b0;
                s_next.ale = 1'b0;
                s_next.oe = 1'b0;
            end
        end else begin
            s_next.cnt = s_reg.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign cle_out = s_reg.cle;
    assign ale_out = s_reg.ale;
    assign we_n_out = !s_reg.we;
    assign re_n_out = !s_reg.re;
    assign io_out = s_reg.dat;
    assign io_oe_out = s_reg.oe;

    AST_WRITE_STROBE_WIDTH: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        $fell(we_n_out) |-> (!we_n_out && io_oe_out)[*2] ##1 (we_n_out && io_oe_out))
        else $error("write strobe width or data hold wrong");

    AST_READ_STROBE_WIDTH: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        $fell(re_n_out) |-> (!re_n_out && !io_oe_out)[*2] ##1 re_n_out)
        else $error("read strobe width wrong");

endmodule

// ==== logic/nand_read_sequencer.sv ====
/*
 * Host controller issuing NAND read sequences: page, cache, two-plane,
 * column change, plane select and status read.
 * Assumes one flash target, io_in synchronous to clk_in, and a user that
 * presents one request at a time and takes read bytes without stalling.
 */
`include "nand_rd_defs.svh"

module nand_read_sequencer #(
    parameter int PAGE_BYTES = `PAGE_BYTES_DEF,
    parameter int PHASE_CYC = `STROBE_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Requests
    input wire logic req_valid_in,
    output logic req_ready_out,
    input wire logic [2:0] req_op_in,
    input wire logic [29:0] req_addr_in,
    input wire logic [12:0] req_len_in,
    // Results
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    output logic done_out,
    output logic err_out,
    output logic [7:0] status_out,
    // Flash pins
    output logic ce_n_out,
    output logic cle_out,
    output logic ale_out,
    output logic we_n_out,
    output logic re_n_out,
    output logic [7:0] io_out,
    output logic io_oe_out,
    input wire logic [7:0] io_in,
    input wire logic ready_busy_n_in
);

    nand_rd_pkg::seq_s s_reg, s_next;
    nand_rd_pkg::op_e req_op;
    logic accept;
    logic refuse;
    logic [13:0] col_end;
    logic [2:0] last_idx;
    logic [29:0] addr_sel;
    logic [29:0] plane_mask;

    nand_cyc_if cyc();

    if (PAGE_BYTES < 1 || PAGE_BYTES > 4096) begin : g_chk
        $error("PAGE_BYTES out of range");
    end

    nand_bus_cycle #(.PHASE_CYC(PHASE_CYC)) u_cycle (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .cyc(cyc),
        .io_in(io_in),
        .cle_out(cle_out),
        .ale_out(ale_out),
        .we_n_out(we_n_out),
        .re_n_out(re_n_out),
        .io_out(io_out),
        .io_oe_out(io_oe_out)
    );

    function automatic logic [7:0] addr_byte(input logic [29:0] a, input logic [2:0] i);
        case (i)
            3'h0: addr_byte = a[`ADDR_B0];
            3'h1: addr_byte = {4'h0, a[`ADDR_B1]};
            3'h2: addr_byte = a[`ADDR_B2];
            3'h3: addr_byte = a[`ADDR_B3];
            default: addr_byte = {6'h00, a[`ADDR_B4]};
        endcase
    endfunction

    assign req_op = nand_rd_pkg::op_e'(req_op_in);
    // Requests are only taken while idle and the device is ready
    assign req_ready_out = (s_reg.state == nand_rd_pkg::S_IDLE) && ready_busy_n_in;
    assign accept = req_valid_in && req_ready_out;
    assign col_end = 14'(req_addr_in[`ADDR_COL]) + 14'(req_len_in);
    assign refuse = (((req_op == nand_rd_pkg::OP_CACHE_SEQ)
                      || (req_op == nand_rd_pkg::OP_CACHE_LAST)) && !s_reg.cache_valid)
                    || ((req_op == nand_rd_pkg::OP_COL_CHANGE)
                        && (!s_reg.cache_valid || (col_end > 14'(PAGE_BYTES))));
    assign last_idx = (s_reg.op == nand_rd_pkg::OP_COL_CHANGE) ?
                      (`ADDR_CYC_COL - 3'h1) : (`ADDR_CYC_FULL - 3'h1);
    assign plane_mask = 30'h00000001 << `PLANE_BIT;
    // Both plane addresses equal except the plane bit
    always_comb begin
        addr_sel = s_reg.addr;
        if (s_reg.op == nand_rd_pkg::OP_TWO_PLANE) begin
            addr_sel = (s_reg.state == nand_rd_pkg::S_ADDR2) ?
                       (s_reg.addr | plane_mask) : (s_reg.addr & ~plane_mask);
        end
    end

    // Bus cycle requests, held until the engine answers
    always_comb begin
        cyc.start = 1'b0;
        cyc.kind = nand_rd_pkg::CYC_CMD;
        cyc.wr_byte = `CMD_READ_SETUP;
        case (s_reg.state)
            nand_rd_pkg::S_RESUME: begin
                cyc.start = 1'b1;
            end
            nand_rd_pkg::S_SETUP: begin
                cyc.start = 1'b1;
                case (s_reg.op)
                    nand_rd_pkg::OP_CACHE_SEQ: cyc.wr_byte = `CMD_CACHE_SEQ;
                    nand_rd_pkg::OP_CACHE_LAST: cyc.wr_byte = `CMD_CACHE_LAST;
                    nand_rd_pkg::OP_COL_CHANGE: cyc.wr_byte = `CMD_COL_CHANGE;
                    nand_rd_pkg::OP_PLANE_SELECT: cyc.wr_byte = `CMD_PLANE_SELECT;
                    nand_rd_pkg::OP_STATUS: cyc.wr_byte = `CMD_STATUS;
                    default: cyc.wr_byte = `CMD_READ_SETUP;
                endcase
            end
            nand_rd_pkg::S_ADDR, nand_rd_pkg::S_ADDR2: begin
                cyc.start = 1'b1;
                cyc.kind = nand_rd_pkg::CYC_ADDR;
                cyc.wr_byte = addr_byte(addr_sel, s_reg.idx);
            end
            nand_rd_pkg::S_SETUP2: begin
                cyc.start = 1'b1;
            end
            nand_rd_pkg::S_CONFIRM: begin
                cyc.start = 1'b1;
                case (s_reg.op)
                    nand_rd_pkg::OP_CACHE_RAND: cyc.wr_byte = `CMD_CACHE_SEQ;
                    nand_rd_pkg::OP_COL_CHANGE,
                    nand_rd_pkg::OP_PLANE_SELECT: cyc.wr_byte = `CMD_OUT_CONFIRM;
                    default: cyc.wr_byte = `CMD_READ_CONFIRM;
                endcase
            end
            nand_rd_pkg::S_DATA: begin
                cyc.start = (s_reg.len != 13'h0000);
                cyc.kind = nand_rd_pkg::CYC_READ;
            end
            default: ;
        endcase
    end

    // Enhanced per-plane status is never issued, so two-plane reads stay safe
    always_comb begin
        s_next = s_reg;
        s_next.rd_valid = 1'b0;
        s_next.done = 1'b0;
        s_next.err = 1'b0;
        case (s_reg.state)
            nand_rd_pkg::S_IDLE: begin
                if (accept) begin
                    s_next.op = req_op;
                    s_next.addr = req_addr_in;
                    s_next.idx = 3'h0;
                    s_next.len = req_len_in;
                    if (req_op == nand_rd_pkg::OP_TWO_PLANE) begin
                        s_next.len = 13'h0000;
                    end else if (req_op == nand_rd_pkg::OP_STATUS) begin
                        s_next.len = 13'h0001;
                    end
                    if (refuse) begin
                        s_next.done = 1'b1;
                        s_next.err = 1'b1;
                    end else begin
                        s_next.ce = 1'b1;
                        s_next.state = ((req_op == nand_rd_pkg::OP_COL_CHANGE) && s_reg.status_mode)
                                       ? nand_rd_pkg::S_RESUME : nand_rd_pkg::S_SETUP;
                    end
                end
            end
            nand_rd_pkg::S_RESUME: begin
                if (cyc.done) begin
                    s_next.status_mode = 1'b0;
                    s_next.state = nand_rd_pkg::S_SETUP;
                end
            end
            nand_rd_pkg::S_SETUP: begin
                if (cyc.done) begin
                    s_next.status_mode = (s_reg.op == nand_rd_pkg::OP_STATUS);
                    case (s_reg.op)
                        nand_rd_pkg::OP_CACHE_SEQ, nand_rd_pkg::OP_CACHE_LAST: begin
                            s_next.wait_cnt = 8'(`WB_CYC);
                            s_next.state = nand_rd_pkg::S_TWB;
                        end
                        nand_rd_pkg::OP_STATUS: begin
                            s_next.wait_cnt = 8'(`WHR_CYC);
                            s_next.state = nand_rd_pkg::S_WRITE_TO_READ_DELAY;
                        end
                        default: s_next.state = nand_rd_pkg::S_ADDR;
                    endcase
                end
            end
            nand_rd_pkg::S_ADDR, nand_rd_pkg::S_ADDR2: begin
                if (cyc.done) begin
                    s_next.idx = s_reg.idx + 3'h1;
                    if (s_reg.idx == last_idx) begin
                        s_next.idx = 3'h0;
                        s_next.state = ((s_reg.state == nand_rd_pkg::S_ADDR)
                                        && (s_reg.op == nand_rd_pkg::OP_TWO_PLANE))
                                       ? nand_rd_pkg::S_SETUP2 : nand_rd_pkg::S_CONFIRM;
                    end
                end
            end
            nand_rd_pkg::S_SETUP2: begin
                if (cyc.done) begin
                    s_next.state = nand_rd_pkg::S_ADDR2;
                end
            end
            nand_rd_pkg::S_CONFIRM: begin
                if (cyc.done) begin
                    if ((s_reg.op == nand_rd_pkg::OP_COL_CHANGE)
                        || (s_reg.op == nand_rd_pkg::OP_PLANE_SELECT)) begin
                        s_next.wait_cnt = 8'(`WHR_CYC);
                        s_next.state = nand_rd_pkg::S_WRITE_TO_READ_DELAY;
                    end else begin
                        s_next.wait_cnt = 8'(`WB_CYC);
                        s_next.state = nand_rd_pkg::S_TWB;
                    end
                end
            end
            nand_rd_pkg::S_TWB, nand_rd_pkg::S_WRITE_TO_READ_DELAY: begin
                s_next.wait_cnt = s_reg.wait_cnt - 8'h01;
                if (s_reg.wait_cnt <= 8'h01) begin
                    s_next.state = (s_reg.state == nand_rd_pkg::S_TWB)
                                   ? nand_rd_pkg::S_BUSY : nand_rd_pkg::S_DATA;
                end
            end
            nand_rd_pkg::S_BUSY: begin
                // Data register is only valid once the device reports ready
                if (ready_busy_n_in) begin
                    s_next.cache_valid = 1'b1;
                    s_next.state = nand_rd_pkg::S_DATA;
                end
            end
            nand_rd_pkg::S_DATA: begin
                if (s_reg.len == 13'h0000) begin
                    s_next.done = 1'b1;
                    s_next.ce = 1'b0;
                    s_next.state = nand_rd_pkg::S_IDLE;
                end else if (cyc.done) begin
                    s_next.len = s_reg.len - 13'h0001;
                    s_next.rd_data = cyc.rd_byte;
                    s_next.rd_valid = 1'b1;
                    if (s_reg.op == nand_rd_pkg::OP_STATUS) begin
                        s_next.status = cyc.rd_byte;
                    end
                end
            end
            default: s_next.state = nand_rd_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign ce_n_out = !s_reg.ce;
    assign rd_data_out = s_reg.rd_data;
    assign rd_valid_out = s_reg.rd_valid;
    assign done_out = s_reg.done;
    assign err_out = s_reg.err;
    assign status_out = s_reg.status;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    AST_PAGE_CONFIRM: assert property (
        (s_reg.state == nand_rd_pkg::S_CONFIRM) && (s_reg.op == nand_rd_pkg::OP_PAGE_READ)
        |-> cyc.start && (cyc.wr_byte == `CMD_READ_CONFIRM))
        else $error("page read confirm code wrong");
    AST_FIVE_ADDR: assert property (
        (s_reg.state == nand_rd_pkg::S_ADDR) && cyc.done && (s_reg.idx == 3'h4)
        && (s_reg.op == nand_rd_pkg::OP_PAGE_READ) |=> (s_reg.state == nand_rd_pkg::S_CONFIRM))
        else $error("confirm not after fifth address");
    AST_WAIT_READY: assert property (
        (s_reg.state == nand_rd_pkg::S_BUSY) && !ready_busy_n_in
        |=> (s_reg.state == nand_rd_pkg::S_BUSY) && !rd_valid_out)
        else $error("left busy wait while device busy");
    AST_RESUME_AFTER_STATUS: assert property (
        accept && !refuse && (req_op == nand_rd_pkg::OP_COL_CHANGE) && s_reg.status_mode
        |=> (s_reg.state == nand_rd_pkg::S_RESUME) && (cyc.wr_byte == `CMD_READ_SETUP))
        else $error("read setup not reissued after status");
    AST_CACHE_NEEDS_READ: assert property (
        accept && ((req_op == nand_rd_pkg::OP_CACHE_SEQ) || (req_op == nand_rd_pkg::OP_CACHE_LAST))
        && !s_reg.cache_valid |=> done_out && err_out && ce_n_out)
        else $error("cache step issued without page read");
    AST_PLANE_BITS: assert property (
        cyc.start && (s_reg.op == nand_rd_pkg::OP_TWO_PLANE) && (s_reg.idx == 3'h2)
        && (s_reg.state == nand_rd_pkg::S_ADDR2 || s_reg.state == nand_rd_pkg::S_ADDR)
        |-> cyc.wr_byte[`PLANE_IO_BIT] == (s_reg.state == nand_rd_pkg::S_ADDR2))
        else $error("plane bit wrong in two-plane address");
    AST_PLANE_CMD: assert property (
        (s_reg.state == nand_rd_pkg::S_SETUP) && (s_reg.op == nand_rd_pkg::OP_PLANE_SELECT)
        |-> cyc.wr_byte == `CMD_PLANE_SELECT)
        else $error("plane select code wrong");
    AST_COL_CMD: assert property (
        (s_reg.state == nand_rd_pkg::S_SETUP) && (s_reg.op == nand_rd_pkg::OP_COL_CHANGE)
        |-> cyc.wr_byte == `CMD_COL_CHANGE)
        else $error("column change code wrong");
    AST_COL_RANGE: assert property (
        accept && (req_op == nand_rd_pkg::OP_COL_CHANGE) && (col_end > 14'(PAGE_BYTES))
        |=> err_out)
        else $error("column change past page accepted");
    AST_WRITE_TO_READ_DELAY: assert property (
        (s_reg.state == nand_rd_pkg::S_CONFIRM) && cyc.done
        && (s_reg.op == nand_rd_pkg::OP_PLANE_SELECT)
        |=> (s_reg.state == nand_rd_pkg::S_WRITE_TO_READ_DELAY)[*2] ##1 (s_reg.state == nand_rd_pkg::S_DATA))
        else $error("write-to-read delay not kept");
    AST_ADDR_PAD: assert property (
        (s_reg.state == nand_rd_pkg::S_ADDR) && cyc.start && (s_reg.idx == 3'h1)
        |-> cyc.wr_byte[7:4] == 4'h0)
        else $error("second address cycle not padded");

    COV_PAGE_READ: cover property ((s_reg.op == nand_rd_pkg::OP_PAGE_READ) && done_out && !err_out);
    COV_TWO_PLANE: cover property ((s_reg.op == nand_rd_pkg::OP_TWO_PLANE) && done_out);
    COV_RESUME: cover property (s_reg.state == nand_rd_pkg::S_RESUME);
    COV_PLANE_DATA: cover property ((s_reg.op == nand_rd_pkg::OP_PLANE_SELECT) && rd_valid_out);

endmodule

// ==== verification/nand_flash_model.sv ====
/* Behavioural flash device on the far side of the read sequencer.
   Assumes one host driving the strobes; busy times in 40 ns units. */
module nand_flash_model #(
    parameter int TR = 20,
    parameter int TC = 10
) (
    // Host pins
    input wire logic ce_n_in,
    input wire logic cle_in,
    input wire logic ale_in,
    input wire logic we_n_in,
    input wire logic re_n_in,
    input wire logic [7:0] io_in,
    // Device pins
    output logic [7:0] io_out,
    output logic ready_busy_n_out
);
    timeunit 1ns / 1ns;
    logic [7:0] cmd = 8'h00;
    logic [39:0] a;
    logic [2:0] n = 0;
    logic [11:0] col;
    logic [17:0] dr, cr;
    logic fill = 0;
    logic idle = 1;
    logic st = 0;
    logic [7:0] dout;
    wire [17:0] ar = {a[33:32], a[31:24], a[23:16]};
    initial ready_busy_n_out = 1;
    assign dout = st ? {1'b1, ready_busy_n_out, idle, 5'h0} : col[7:0] ^ cr[7:0];
    // Released bus shows the inverse, not a stale byte
    assign io_out = (re_n_in | ce_n_in) ? ~dout : dout;
    task automatic busy(input int t);
        ready_busy_n_out = 0;
        // Half a period late, so ready never moves on a sampling edge
        #(t * 40 + 20);
        ready_busy_n_out = 1;
    endtask
    always @(posedge re_n_in) if (!ce_n_in && !st) col <= col + 1;
    always @(posedge we_n_in) if (!ce_n_in) begin
        if (ale_in) begin
            a[n*8 +: 8] <= io_in;
            n <= n + 1;
        end
        if (cle_in) begin
            cmd <= io_in;
            n <= 0;
            st <= io_in == 8'h70;
            case (io_in)
                8'h30: begin
                    dr <= ar;
                    cr <= ar;
                    col <= a[11:0];
                    fill <= 1;
                    idle <= 1;
                    busy(TR);
                end
                8'h31: if (fill) begin
                    cr <= dr;
                    dr <= (n == 5) ? ar : dr + 1;
                    col <= 0;
                    idle <= 0;
                    busy(TC);
                end
                8'h3F: if (fill) begin
                    cr <= dr;
                    col <= 0;
                    idle <= 1;
                    busy(TC);
                end
                8'hE0: begin
                    col <= a[11:0];
                    if (cmd == 8'h06) cr <= ar;
                end
                default: ;
            endcase
        end
    end
endmodule

// ==== verification/nand_read_sequencer_tb.sv ====
/* Self-checking bench of the NAND read sequencer with the device model.
   Assumes the model in the same library and a 25 MHz clock. */
module nand_read_sequencer_tb;
    timeunit 1ns / 1ns;
    logic clk_in = 0, rst_n_in = 0, req_valid_in = 0;
    logic [2:0] req_op_in = 0;
    logic [29:0] req_addr_in = 0;
    logic [12:0] req_len_in = 0;
    logic [7:0] rd_data_out, status_out, io_out, io_in;
    logic req_ready_out, rd_valid_out, done_out, err_out, ce_n_out, cle_out, ale_out;
    logic we_n_out, re_n_out, io_oe_out, rb;
    int mismatches = 0, checks = 0;
    nand_read_sequencer dut (.clk_in, .rst_n_in, .req_valid_in, .req_ready_out, .req_op_in,
        .req_addr_in, .req_len_in, .rd_data_out, .rd_valid_out, .done_out, .err_out,
        .status_out, .ce_n_out, .cle_out, .ale_out, .we_n_out, .re_n_out, .io_out,
        .io_oe_out, .io_in, .ready_busy_n_in(rb));
    nand_flash_model dev (.ce_n_in(ce_n_out), .cle_in(cle_out), .ale_in(ale_out),
        .we_n_in(we_n_out), .re_n_in(re_n_out), .io_in(io_out), .io_out(io_in),
        .ready_busy_n_out(rb));
    initial forever #20 clk_in = ~clk_in;
    task automatic results;
        if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [2:0] op, input logic [29:0] a, input logic [12:0] n,
            input logic [11:0] c, input logic [7:0] r, input logic e);
        int k;
        logic [12:0] i;
        i = 0;
        for (k = 0; req_ready_out !== 1'b1; k++) begin
            if (k > 9000) mismatches++;
            if (k > 9000) results();
            @(negedge clk_in);
        end
        req_valid_in = 1;
        req_op_in = op;
        req_addr_in = a;
        req_len_in = n;
        @(negedge clk_in);
        req_valid_in = 0;
        for (k = 0; done_out !== 1'b1; k++) begin
            if (k > 9000) mismatches++;
            if (k > 9000) results();
            if (rd_valid_out === 1'b1 && op != 3'h7) chk(rd_data_out, 8'(c + i) ^ r);
            if (rd_valid_out === 1'b1) i++;
            @(negedge clk_in);
        end
        chk(err_out, e);
        if (op != 3'h7) chk(i, e ? 13'h0 : n);
        @(negedge clk_in);
    endtask
    task automatic refuse_first;
        run(3'h1, 0, 2, 0, 0, 1);
        run(3'h3, 0, 2, 0, 0, 1);
    endtask
    task automatic page_and_column;
        run(3'h0, {18'h00123, 12'hFFD}, 3, 12'hFFD, 8'h23, 0);
        run(3'h5, {18'h0, 12'h064}, 4, 12'h064, 8'h23, 0);
        run(3'h5, {18'h0, 12'hFFA}, 10, 0, 0, 1);
    endtask
    task automatic cache_steps;
        run(3'h2, {18'h00005, 12'h04D}, 2, 0, 8'h23, 0);
        run(3'h1, 0, 2, 0, 8'h05, 0);
        run(3'h3, 0, 2, 0, 8'h06, 0);
    endtask
    task automatic status_then_data;
        run(3'h7, 0, 1, 0, 0, 0);
        chk(status_out, 8'hE0);
        run(3'h5, {18'h0, 12'h008}, 2, 12'h008, 8'h06, 0);
    endtask
    task automatic two_plane;
        run(3'h4, {18'h00201, 12'h0}, 0, 0, 0, 0);
        run(3'h6, {18'h00241, 12'h00A}, 2, 12'h00A, 8'h41, 0);
        run(3'h6, {18'h00201, 12'h010}, 2, 12'h010, 8'h01, 0);
    endtask
    initial begin
        repeat (4) @(negedge clk_in);
        rst_n_in = 1;
        @(negedge clk_in);
        refuse_first();
        page_and_column();
        cache_steps();
        status_then_data();
        two_plane();
        results();
    end
endmodule
